// ---- src/voice_dev_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module voice_dev_end
  import voice_pkg::*;
(
  input  wire logic       i_osc_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_serial_mode,
  input  wire logic       i_play_done,
  voice_link_if.dev_end   lnk,
  output logic            o_play_start,
  output logic            o_play_lane,
  output logic [6:0]      o_play_phrase,
  output logic            o_route_lpf,
  output logic            o_speech_mute,
  output logic            o_cmd_stb,
  output logic [6:0]      o_cmd_code
);

  logic              rst_n;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic              launch_q_r;
  logic              sclk_q_r;
  logic              launch_fall;
  logic              launch_rise;
  logic              sclk_rise;
  logic              strap_done_r;
  logic              serial_r;
  logic [1:0]        mode_sync_r;
  logic [1:0]        strap_age_r;
  logic [WORD_W-1:0] shift_r;
  logic              accepted_r;
  logic              is_cmd_r;
  logic              is_cmd_nxt;
  logic              nar_r;
  logic [2:0]        nar_cnt_r;
  logic              playing_r;
  logic [6:0]        code_nxt;
  logic [1:0]        port_r;
  logic              take_code;

  // Either the local reset or the host's reset pulse stops the device
  assign rst_n = i_rst_n & lnk.dev_rst_n;

  // Two-flop synchroniser for every host pin except the reset pulse
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {lnk.phrase_launch_n, lnk.cmd_sel,
                  lnk.voice_lane_sel, lnk.phrase_line};
      sync2_r <= sync1_r;
    end
  end

  // Edge history taken from the second synchroniser stage only
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_q_r <= 1'b1;
      sclk_q_r   <= 1'b0;
    end else begin
      launch_q_r <= sync2_r[S_LAUNCH];
      sclk_q_r   <= sync2_r[SCK_BIT];
    end
  end

  assign launch_fall = launch_q_r & ~sync2_r[S_LAUNCH];
  assign launch_rise = ~launch_q_r & sync2_r[S_LAUNCH];
  assign sclk_rise   = ~sclk_q_r & sync2_r[SCK_BIT];

  // Option strap pin through two flops, caught once when both are filled
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_sync_r  <= '0;
      strap_age_r  <= '0;
      strap_done_r <= 1'b0;
      serial_r     <= 1'b0;
    end else begin
      mode_sync_r <= {mode_sync_r[0], i_serial_mode};
      if (!strap_age_r[1]) begin
        strap_age_r <= {strap_age_r[0], 1'b1};
      end else if (!strap_done_r) begin
        strap_done_r <= 1'b1;
        serial_r     <= mode_sync_r[1];
      end
    end
  end

  // Serial word shifter, MSB first on the rising serial clock
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (serial_r && sclk_rise) begin
      shift_r <= {shift_r[WORD_W-2:0], sync2_r[SD_BIT]};
    end
  end

  // Command or phrase: serial flag bit, else select pin at the fall
  always_comb begin
    if (serial_r) begin
      is_cmd_nxt = shift_r[CMD_FLAG_BIT];
    end else begin
      is_cmd_nxt = sync2_r[S_CMD];
    end
  end

  // Code source: shifted word or the seven parallel lines
  always_comb begin
    if (serial_r) begin
      code_nxt = shift_r[CODE_W-1:0];
    end else begin
      code_nxt = sync2_r[CODE_W-1:0];
    end
  end

  assign take_code = accepted_r & launch_rise;

  // Strobe acceptance: a fall counts only while ready is high
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      accepted_r <= 1'b0;
      is_cmd_r   <= 1'b0;
    end else if (launch_fall && nar_r) begin
      accepted_r <= 1'b1;
      is_cmd_r   <= is_cmd_nxt;
    end else if (launch_rise) begin
      accepted_r <= 1'b0;
    end
  end

  // Ready: drops on an accepted strobe, returns after a short hold
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      nar_r     <= 1'b1;
      nar_cnt_r <= '0;
    end else if (launch_fall && nar_r) begin
      nar_r     <= 1'b0;
      nar_cnt_r <= NAR_HOLD_CYC;
    end else if (!nar_r && !accepted_r) begin
      if (nar_cnt_r == '0) begin
        nar_r <= 1'b1;
      end else begin
        nar_cnt_r <= nar_cnt_r - 3'h1;
      end
    end
  end

  // Playback state: set at the strobe fall, cleared by done or stop
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      playing_r <= 1'b0;
    end else if (launch_fall && nar_r && !is_cmd_nxt) begin
      playing_r <= 1'b1;
    end else if (i_play_done) begin
      playing_r <= 1'b0;
    end else if (take_code && is_cmd_r && code_nxt == CMD_STOP) begin
      playing_r <= 1'b0;
    end
  end

  // Phrase hand-off to the synthesis core at the strobe rise
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_play_start  <= 1'b0;
      o_play_phrase <= '0;
      o_play_lane   <= 1'b1;
    end else begin
      o_play_start <= take_code & ~is_cmd_r;
      if (take_code && !is_cmd_r) begin
        o_play_phrase <= code_nxt;
        o_play_lane   <= sync2_r[S_LANE];
      end
    end
  end

  // Command strobe and code for the synthesis core
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_cmd_stb  <= 1'b0;
      o_cmd_code <= '0;
    end else begin
      o_cmd_stb <= take_code & is_cmd_r;
      if (take_code && is_cmd_r) begin
        o_cmd_code <= code_nxt;
      end
    end
  end

  // Output routing selected by command, converter after reset
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_route_lpf <= 1'b0;
    end else if (take_code && is_cmd_r) begin
      if (code_nxt == CMD_ROUTE_LPF) begin
        o_route_lpf <= 1'b1;
      end else if (code_nxt == CMD_ROUTE_DAC) begin
        o_route_lpf <= 1'b0;
      end
    end
  end

  // Port outputs loaded by the silence insertion code
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_r <= '0;
    end else if (take_code && serial_r &&
                 code_nxt[CODE_W-1:PORT0_BIT] == SIL_PREFIX) begin
      port_r <= code_nxt[1:0];
    end
  end

  // Speech output held at ground in reset, released afterwards
  always_ff @(posedge i_osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_speech_mute <= 1'b1;
    end else begin
      o_speech_mute <= 1'b0;
    end
  end

  // Link outputs
  assign lnk.addr_accept_ready = nar_r;
  assign lnk.playing_n         = ~playing_r;
  assign lnk.gp_out            = port_r;
  assign lnk.gp_oe             = serial_r;

endmodule : voice_dev_end
`default_nettype wire

// ---- src/voice_host_end.sv ----
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module voice_host_end
  import voice_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  voice_link_if.host_end   lnk
);

  hseq_t             st_r;
  logic [7:0]        cnt_r;
  logic [2:0]        bit_r;
  logic [1:0]        ctrl_r;
  logic [WORD_W-1:0] word_r;
  logic              pend_r;
  logic [1:0]        in1_r;
  logic [1:0]        in2_r;
  logic              aw_hold_r;
  logic              w_hold_r;
  logic [3:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic              wstrb0_r;
  logic              do_write;
  logic              cmd_write;
  logic              launch_n_r;
  logic              sclk_r;
  logic              sdat_r;

  // Device ready and playing levels through two flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in1_r <= 2'h1;
      in2_r <= 2'h1;
    end else begin
      in1_r <= {lnk.addr_accept_ready, lnk.playing_n};
      in2_r <= in1_r;
    end
  end

  // AXI write: address and data taken in either order
  assign o_s_axi_awready = ~aw_hold_r & ~o_s_axi_bvalid;
  assign o_s_axi_wready  = ~w_hold_r & ~o_s_axi_bvalid;
  assign do_write        = aw_hold_r & w_hold_r & ~o_s_axi_bvalid;
  assign cmd_write       = do_write & (awaddr_r == REG_CMD) & wstrb0_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_hold_r      <= 1'b0;
      w_hold_r       <= 1'b0;
      awaddr_r       <= '0;
      wdata_r        <= '0;
      wstrb0_r       <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= AXI_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= i_s_axi_awaddr[3:0];
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= i_s_axi_wdata;
        wstrb0_r <= i_s_axi_wstrb[0];  // Lane strobe travels with its data
      end
      if (do_write) begin
        aw_hold_r      <= 1'b0;
        w_hold_r       <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (awaddr_r == REG_CTRL || awaddr_r == REG_CMD ||
                           awaddr_r == REG_STATUS) ? AXI_OKAY : AXI_SLVERR;
      end else if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register: serial option and lane select
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (do_write && awaddr_r == REG_CTRL && wstrb0_r) begin
      ctrl_r <= wdata_r[1:0];
    end
  end

  // AXI read: status reflects the sequencer and the device pins
  assign o_s_axi_arready = ~o_s_axi_rvalid;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= '0;
      o_s_axi_rresp  <= AXI_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rresp  <= AXI_OKAY;
      case (i_s_axi_araddr[3:0])
        REG_CTRL:   o_s_axi_rdata <= {30'h0, ctrl_r};
        REG_CMD:    o_s_axi_rdata <= {24'h0, word_r};
        REG_STATUS: o_s_axi_rdata <= {28'h0, st_r == H_RST, ~in2_r[0],
                                      in2_r[1], pend_r | (st_r != H_IDLE)};
        default: begin
          o_s_axi_rdata <= '0;
          o_s_axi_rresp <= AXI_SLVERR;
        end
      endcase
    end else if (i_s_axi_rready) begin
      o_s_axi_rvalid <= 1'b0;
    end
  end

  // Order sequencer: reset pulse, wait ready, shift, strobe, gap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r       <= H_RST;
      cnt_r      <= RST_CYC_8;
      bit_r      <= '0;
      pend_r     <= 1'b0;
      word_r     <= '0;
      launch_n_r <= 1'b1;
      sclk_r     <= 1'b0;
      sdat_r     <= 1'b0;
    end else begin
      if (cmd_write && !pend_r && st_r == H_IDLE) begin
        pend_r <= 1'b1;
        word_r <= wdata_r[WORD_W-1:0];
      end
      case (st_r)
        H_RST: begin
          if (cnt_r == '0) begin
            st_r <= H_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h1;
          end
        end
        H_IDLE: begin
          if (pend_r) begin
            st_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (in2_r[1]) begin
            pend_r <= 1'b0;
            bit_r  <= '0;
            cnt_r  <= SCLK_HALF_CYC;
            sdat_r <= word_r[CMD_FLAG_BIT];
            st_r   <= ctrl_r[CTRL_SERIAL] ? H_SHIFT : H_LOW;
            if (!ctrl_r[CTRL_SERIAL]) begin
              launch_n_r <= 1'b0;
              cnt_r      <= LAUNCH_LOW_CYC;
            end
          end
        end
        H_SHIFT: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 8'h1;
          end else if (!sclk_r) begin
            sclk_r <= 1'b1;
            cnt_r  <= SCLK_HALF_CYC;
          end else begin
            sclk_r <= 1'b0;
            cnt_r  <= SCLK_HALF_CYC;
            bit_r  <= bit_r + 3'h1;
            sdat_r <= word_r[3'(CMD_FLAG_BIT) - bit_r - 3'h1];
            if (bit_r == 3'(CMD_FLAG_BIT)) begin
              launch_n_r <= 1'b0;
              cnt_r      <= LAUNCH_LOW_CYC;
              st_r       <= H_LOW;
            end
          end
        end
        H_LOW: begin
          if (cnt_r == '0) begin
            launch_n_r <= 1'b1;
            cnt_r      <= GAP_CYC;
            st_r       <= H_GAP;
          end else begin
            cnt_r <= cnt_r - 8'h1;
          end
        end
        H_GAP: begin
          if (cnt_r == '0) begin
            st_r <= H_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h1;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  // Link pins: parallel code or serial data/clock with low spares
  assign lnk.dev_rst_n       = (st_r != H_RST);
  assign lnk.phrase_launch_n = launch_n_r;
  assign lnk.voice_lane_sel  = ctrl_r[CTRL_LANE];
  assign lnk.cmd_sel         = ctrl_r[CTRL_SERIAL] | (st_r == H_IDLE) |
                               word_r[CMD_FLAG_BIT];
  assign lnk.host_pin_oe     = ctrl_r[CTRL_SERIAL] ? SER_HOST_OE
                                                   : PAR_HOST_OE;
  assign lnk.host_pin_out    = ctrl_r[CTRL_SERIAL] ?
                               {sdat_r, sclk_r, 5'h00} :
                               word_r[CODE_W-1:0];

endmodule : voice_host_end
`default_nettype wire

// ---- src/voice_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface voice_link_if;
  import voice_pkg::*;
  logic       dev_rst_n;
  logic       phrase_launch_n;
  logic       cmd_sel;
  logic       voice_lane_sel;
  logic [6:0] host_pin_out;
  logic [6:0] host_pin_oe;
  logic [1:0] gp_out;
  logic       gp_oe;
  logic       addr_accept_ready;
  logic       playing_n;
  logic [6:0] phrase_line;

  // Wire level: host drive, else device port drive, else pull-down
  always_comb begin
    phrase_line = host_pin_out & host_pin_oe;
    if (gp_oe && !host_pin_oe[PORT0_BIT]) begin
      phrase_line[PORT0_BIT] = gp_out[0];
    end
    if (gp_oe && !host_pin_oe[PORT1_BIT]) begin
      phrase_line[PORT1_BIT] = gp_out[1];
    end
  end

  modport host_end (
    output dev_rst_n, phrase_launch_n, cmd_sel, voice_lane_sel,
    output host_pin_out, host_pin_oe,
    input  addr_accept_ready, playing_n, phrase_line
  );
  modport dev_end (
    input  dev_rst_n, phrase_launch_n, cmd_sel, voice_lane_sel,
    input  phrase_line,
    output gp_out, gp_oe, addr_accept_ready, playing_n
  );
endinterface : voice_link_if
`default_nettype wire

// ---- src/voice_pkg.sv ----
package voice_pkg;
  // Link word layout
  localparam int         CODE_W       = 7;
  localparam int         WORD_W       = 8;
  localparam int         CMD_FLAG_BIT = 7;
  localparam int         SD_BIT       = 6;
  localparam int         SCK_BIT      = 5;
  localparam int         PORT0_BIT    = 2;
  localparam int         PORT1_BIT    = 3;
  localparam logic [6:0] SER_HOST_OE  = 7'h73;
  localparam logic [6:0] PAR_HOST_OE  = 7'h7F;

  // Command codes
  localparam logic [6:0] CMD_ROUTE_DAC = 7'h01;
  localparam logic [6:0] CMD_ROUTE_LPF = 7'h02;
  localparam logic [6:0] CMD_STOP      = 7'h03;
  localparam logic [4:0] SIL_PREFIX    = 5'h1F;

  // Pin synchroniser: launch, cmd_sel, lane, seven phrase lines
  localparam int          SYNC_W   = 10;
  localparam logic [9:0]  SYNC_RST = 10'h380;
  localparam int          S_LAUNCH = 9;
  localparam int          S_CMD    = 8;
  localparam int          S_LANE   = 7;

  // Device timing in oscillator cycles
  localparam logic [2:0] NAR_HOLD_CYC = 3'h4;

  // Host timing
  localparam int         HOST_CLK_NS    = 40;
  localparam int         RST_PULSE_NS   = 2000;
  localparam int         RST_PULSE_CYC  =
    (RST_PULSE_NS + HOST_CLK_NS - 1) / HOST_CLK_NS;
  localparam logic [7:0] RST_CYC_8      = 8'(RST_PULSE_CYC);
  localparam logic [7:0] SCLK_HALF_CYC  = 8'h08;
  localparam logic [7:0] LAUNCH_LOW_CYC = 8'h08;
  localparam logic [7:0] GAP_CYC        = 8'h10;

  // Host register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CMD    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int         CTRL_SERIAL = 0;
  localparam int         CTRL_LANE   = 1;
  localparam logic [1:0] CTRL_RST    = 2'h2;
  localparam logic [1:0] AXI_OKAY    = 2'h0;
  localparam logic [1:0] AXI_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    H_RST, H_IDLE, H_WAIT, H_SHIFT, H_LOW, H_GAP
  } hseq_t;
endpackage : voice_pkg

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import voice_pkg::*;
  logic        clk, osc;
  logic        rst_n = 1'b0, ser = 1'b0, done = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        play_start, play_lane, route_lpf, mute, cmd_stb, ln;
  logic        last_lane;
  logic [6:0]  play_phrase, cmd_code, last_ph, last_cmd, ph;
  int          num_errors = 0, n_compared = 0, n_play = 0, n_cmd = 0;
  int          cyc = 0, k;

  voice_link_if lnk ();
  voice_host_end voice_host_end_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .lnk(lnk));
  voice_dev_end voice_dev_end_i (.i_osc_clk(osc), .i_rst_n(rst_n),
    .i_serial_mode(ser), .i_play_done(done), .lnk(lnk),
    .o_play_start(play_start), .o_play_lane(play_lane),
    .o_play_phrase(play_phrase), .o_route_lpf(route_lpf),
    .o_speech_mute(mute), .o_cmd_stb(cmd_stb), .o_cmd_code(cmd_code));
  voice_link_checker voice_link_checker_i (.i_osc_clk(osc),
    .i_rst_n(rst_n), .dev_rst_n(lnk.dev_rst_n),
    .phrase_launch_n(lnk.phrase_launch_n), .cmd_sel(lnk.cmd_sel),
    .host_pin_oe(lnk.host_pin_oe), .phrase_line(lnk.phrase_line),
    .gp_oe(lnk.gp_oe), .addr_accept_ready(lnk.addr_accept_ready),
    .playing_n(lnk.playing_n));

  // System clock 40 ns, link clock 32 ns with an offset
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #7;
    forever #16 osc = ~osc;
  end

  // Collect device pulses between link clock edges
  always @(negedge osc) begin
    if (play_start === 1'b1) begin
      n_play++;
      last_ph = play_phrase;
      last_lane = play_lane;
    end
    if (cmd_stb === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_code;
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      num_errors++;
      end_sim();
    end
  end

  task end_sim;
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  function automatic logic exp_lpf(input logic [6:0] c);
    return c == CMD_ROUTE_LPF;
  endfunction : exp_lpf

  function automatic logic [1:0] exp_port(input logic [6:0] c);
    return c[1:0];
  endfunction : exp_port

  // Write with both channels offered together, response into r
  task axi_wr(input logic [31:0] a, input logic [31:0] dd);
    logic ta, tw, ka, kw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ka = awvalid && awready;
      kw = wvalid && wready;
      @(posedge clk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
      ta = ta | ka;
      tw = tw | kw;
    end
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
  endtask : axi_wr

  // Read into d and r
  task axi_rd(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd

  // Issue one link word and wait for the sequencer to go idle
  task send(input logic [7:0] w);
    axi_wr({28'h0, REG_CMD}, {24'h0, w});
    d = 32'h1;
    while (d[0] !== 1'b0) axi_rd({28'h0, REG_STATUS});
    repeat (8) @(posedge clk);
  endtask : send

  task end_play;
    @(posedge osc);
    done <= 1'b1;
    @(posedge osc);
    done <= 1'b0;
    repeat (4) @(negedge osc);
    chk(lnk.playing_n === 1'b1, "playing not cleared");
  endtask : end_play

  task do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    ser <= s;
    repeat (10) @(posedge clk);
    chk(lnk.addr_accept_ready === 1'b1 && lnk.playing_n === 1'b1 &&
        mute === 1'b1 && lnk.gp_oe === 1'b0, "reset levels");
    rst_n <= 1'b1;
    axi_rd({28'h0, REG_STATUS});
    chk(d[3] === 1'b1 && lnk.dev_rst_n === 1'b0, "reset pulse");
    while (lnk.dev_rst_n !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(mute === 1'b0 && lnk.addr_accept_ready === 1'b1, "after reset");
  endtask : do_reset

  // Main sequence
  initial begin
    ph = 7'($urandom(32'h7a9bb91e));
    do_reset(1'b0);
    axi_rd({28'h0, REG_CTRL});
    chk(d === 32'h2 && r === AXI_OKAY, "ctrl reset value");
    axi_rd(32'hC);
    chk(d === 32'h0 && r === AXI_SLVERR, "unmapped read");
    axi_wr(32'hC, 32'h5);
    chk(r === AXI_SLVERR, "unmapped write");
    for (int i = 0; i < 2; i++) begin
      ph = i ? CMD_ROUTE_DAC : CMD_ROUTE_LPF;
      k = n_cmd;
      send({1'b1, ph});
      chk(n_cmd == k + 1 && last_cmd === ph, "command code");
      chk(route_lpf === exp_lpf(ph), "output route");
      chk(lnk.playing_n === 1'b1, "command played");
    end
    for (int i = 0; i < 8; i++) begin
      ph = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($urandom);
      ln = 1'($urandom);
      axi_wr({28'h0, REG_CTRL}, {30'h0, ln, 1'b0});
      k = n_play;
      send({1'b0, ph});
      chk(n_play == k + 1 && last_ph === ph, "phrase code");
      chk(last_lane === ln, "lane");
      chk(lnk.playing_n === 1'b0, "not playing");
      axi_rd({28'h0, REG_STATUS});
      chk(d[2:1] === 2'h3 && r === AXI_OKAY, "status bits");
      if (i % 2 == 1) begin
        send({1'b1, CMD_STOP});
        chk(lnk.playing_n === 1'b1, "stop ignored");
      end else begin
        end_play();
      end
    end
    k = n_play;
    axi_wr({28'h0, REG_CMD}, 32'h15);
    send(8'h26);
    chk(n_play == k + 1 && last_ph === 7'h15, "overlap not refused");
    end_play();
    do_reset(1'b1);
    axi_wr({28'h0, REG_CTRL}, 32'h3);
    chk(lnk.gp_oe === 1'b1, "port drive off");
    for (int i = 0; i < 4; i++) begin
      ph = {SIL_PREFIX, 2'(3 - i)};
      send({1'b1, ph});
      chk(lnk.phrase_line[3:2] === exp_port(ph), "port level");
    end
    send({1'b1, CMD_ROUTE_LPF});
    chk(route_lpf === 1'b1, "serial route");
    for (int i = 0; i < 3; i++) begin
      ph = 7'($urandom);
      k = n_play;
      send({1'b0, ph});
      chk(n_play == k + 1 && last_ph === ph, "serial phrase");
    end
    chk(lnk.playing_n === 1'b0, "serial not playing");
    do_reset(1'b0);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire

// ---- verif/voice_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module voice_link_checker
  import voice_pkg::*;
(
  input wire logic       i_osc_clk,
  input wire logic       i_rst_n,
  input wire logic       dev_rst_n,
  input wire logic       phrase_launch_n,
  input wire logic       cmd_sel,
  input wire logic [6:0] host_pin_oe,
  input wire logic [6:0] phrase_line,
  input wire logic       gp_oe,
  input wire logic       addr_accept_ready,
  input wire logic       playing_n
);
  // Link logic runs on the oscillator clock; both resets stop checking
  default clocking cb @(posedge i_osc_clk);
  endclocking
  default disable iff (!(i_rst_n && dev_rst_n));

  // Device held in reset shows its idle levels
  a_reset_idle: assert property (
    disable iff (!i_rst_n)
    !dev_rst_n |-> addr_accept_ready && playing_n && !gp_oe)
    else $error("device outputs not idle while in reset");

  // An accepted strobe fall takes the ready line down
  a_ready_drop: assert property (
    $fell(phrase_launch_n) && addr_accept_ready && !gp_oe
    |-> ##[1:6] !addr_accept_ready)
    else $error("ready did not drop after accepted strobe");

  // A phrase strobe starts playback at its falling edge
  a_play_begin: assert property (
    $fell(phrase_launch_n) && addr_accept_ready && !gp_oe && !cmd_sel
    |-> ##[1:6] !playing_n)
    else $error("playback did not begin after phrase strobe");

  // A command strobe never starts playback
  a_cmd_no_play: assert property (
    $fell(phrase_launch_n) && addr_accept_ready && !gp_oe && cmd_sel &&
    playing_n |=> playing_n [*6])
    else $error("command strobe started playback");

  // Ready stays low while the strobe is still being handled
  a_ready_hold: assert property (
    $fell(addr_accept_ready) && !gp_oe |-> !addr_accept_ready [*8])
    else $error("ready came back too early");

  // Ready returns soon after the strobe rises
  a_ready_back: assert property (
    $rose(phrase_launch_n) && !addr_accept_ready && !gp_oe
    |-> ##[1:14] addr_accept_ready)
    else $error("ready did not return after strobe rise");

  // Serial host keeps command select high
  a_serial_cmd: assert property (
    host_pin_oe == SER_HOST_OE |-> cmd_sel)
    else $error("command select low in serial mode");

  // Serial host holds unused lines low
  a_serial_low: assert property (
    host_pin_oe == SER_HOST_OE |-> (phrase_line & 7'h13) == 7'h00)
    else $error("unused lines not low in serial mode");
endmodule : voice_link_checker
`default_nettype wire
